// ==== dv/tcs_capture_sink_props.sv ====
`timescale 1ns/1ns
module tcs_capture_sink_props import tcs_pkg::*; (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // Stream and control
  input wire logic               trace_valid,
  input wire logic [ID_W-1:0]    trace_id,
  input wire logic [ID_W-1:0]    owner_id,
  input wire logic               multi_src,
  input wire logic               pack_trig,
  input wire logic               dbg_auth_ok,
  input wire logic               event0,
  input wire logic               event0_en,
  input wire logic               stop_on_trig,
  input wire logic [FILL_W-1:0]  post_trig_words,
  input wire logic               circ_mode,
  input wire logic [FILL_W-1:0]  watermark,
  input wire logic [NUM_EVT-1:0] irq_en,
  input wire logic [NUM_EVT-1:0] irq_clr,
  // Status and interrupts
  input wire logic               cap_active_q,
  input wire logic               triggered_q,
  input wire logic [PTR_W-1:0]   wr_ptr_q,
  input wire logic [FILL_W-1:0]  fill_q,
  input wire logic [CNT_W-1:0]   drop_cnt_q,
  input wire logic [NUM_EVT-1:0] irq_status_q,
  input wire logic               core_private_irq_q,
  input wire logic               shared_irq_q,
  input wire logic               message_locality_irq_q
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Capture and interrupt behaviour; $past guards keep reset-time values out
  a_trig_stop: assert property (
    cap_active_q && !triggered_q && event0 && event0_en && stop_on_trig && post_trig_words == FILL_ZERO
    |=> !cap_active_q) else $error("event 0 did not stop capture");
  a_trig_drop: assert property (
    cap_active_q && trace_valid && trace_id == TRIG_ID && !pack_trig |=> $stable(wr_ptr_q))
    else $error("unpacked trigger beat was stored");
  a_foreign_drop: assert property (
    cap_active_q && dbg_auth_ok && !multi_src && trace_valid && trace_id != owner_id && trace_id != TRIG_ID
    |=> $stable(wr_ptr_q) && (drop_cnt_q == $past(drop_cnt_q) + CNT_ONE || drop_cnt_q == CNT_MAX))
    else $error("foreign beat stored or not counted");
  a_wrap_flag: assert property (
    $past(circ_mode) && $past(cap_active_q) && $past(wr_ptr_q) == PTR_LAST && wr_ptr_q == PTR_ZERO
    |-> irq_status_q[EVT_WRAP]) else $error("wrap flag missing");
  a_wm_flag: assert property (
    watermark != FILL_ZERO && $stable(watermark) && $past(fill_q) < watermark && fill_q >= watermark
    |-> irq_status_q[EVT_WM]) else $error("watermark flag missing");
  a_shared_irq: assert property (
    shared_irq_q == |(irq_status_q & $past(irq_en))) else $error("shared line wrong");
  a_msg_pulse: assert property (
    message_locality_irq_q == (shared_irq_q && !$past(shared_irq_q))) else $error("message irq not one pulse");
  a_no_private: assert property (
    multi_src && $past(multi_src) && $past(multi_src, 2) |-> !core_private_irq_q)
    else $error("private line used by shared buffer");
  a_sticky_wm: assert property (
    irq_status_q[EVT_WM] && !irq_clr[EVT_WM] |=> irq_status_q[EVT_WM]) else $error("flag lost");

  // Main scenarios reached
  c_wrap: cover property (irq_status_q[EVT_WRAP]);
  c_trig: cover property (triggered_q && !cap_active_q);
  c_shared: cover property (shared_irq_q && !core_private_irq_q);
endmodule

// ==== dv/tcs_capture_sink_test.sv ====
`timescale 1ns/1ns
module tcs_capture_sink_test;
  import tcs_pkg::*;
  // Controls driven by the bench
  logic                clk = 1'b0, rst = 1'b1, cap_start = 1'b0, cap_stop = 1'b0, rd_req = 1'b0;
  logic                circ_mode = 1'b0, multi_src = 1'b0, pack_trig = 1'b0, trig_id_en = 1'b0;
  logic                event0_en = 1'b0, stop_on_trig = 1'b0, dbg_auth_ok = 1'b1;
  logic [PTR_W-1:0]    rd_addr = PTR_ZERO;
  logic [ID_W-1:0]     owner_id = 7'h05;
  logic [FILL_W-1:0]   post_trig_words = FILL_ZERO, watermark = 9'h003;
  logic [NUM_EVT-1:0]  irq_en = 3'h7, irq_clr = EVT_NONE;
  // Stream and design outputs
  logic                trace_valid, event0, trace_ready_q, rd_valid_q, cap_active_q, triggered_q;
  logic                core_private_irq_q, shared_irq_q, message_locality_irq_q;
  logic [ID_W-1:0]     trace_id;
  logic [DATA_W-1:0]   trace_data, dv[4];
  logic [WORD_W-1:0]   rd_data_q, exp_q[$];
  logic [PTR_W-1:0]    wr_ptr_q;
  logic [FILL_W-1:0]   fill_q;
  logic [CNT_W-1:0]    drop_cnt_q;
  logic [NUM_EVT-1:0]  irq_status_q;
  logic [31:0]         lf = 32'h0000_004a;
  int                  failures = 0, check_count = 0, cycles = 0;

  tcs_capture_sink dut (.clk, .rst, .trace_valid, .trace_id, .trace_data, .trace_ready_q, .event0, .cap_start,
    .cap_stop, .circ_mode, .multi_src, .pack_trig, .trig_id_en, .event0_en, .stop_on_trig, .post_trig_words,
    .owner_id, .dbg_auth_ok, .watermark, .irq_en, .irq_clr, .rd_req, .rd_addr, .rd_data_q, .rd_valid_q,
    .cap_active_q, .triggered_q, .wr_ptr_q, .fill_q, .drop_cnt_q, .irq_status_q, .core_private_irq_q,
    .shared_irq_q, .message_locality_irq_q);
  tcs_trace_src src (.clk, .ready(trace_ready_q), .valid(trace_valid), .id(trace_id), .data(trace_data),
    .evt0(event0));

  // 100 MHz clock
  always #5 clk = ~clk;

  // Pseudo-random payload, stepped per beat
  function automatic logic [31:0] nxt();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction

  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    check(WORD_W'(exp_q.size()), WORD_ZERO);
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Start pulse, then one edge for the run state to land
  task automatic go();
    cap_start <= 1'b1;
    cyc(1);
    cap_start <= 1'b0;
    cyc(1);
  endtask

  task automatic clr();
    irq_clr <= 3'h7;
    cyc(1);
    irq_clr <= EVT_NONE;
    cyc(3);
  endtask

  // Read request; the expected word waits in the queue
  task automatic rd(input logic [PTR_W-1:0] a, input logic [WORD_W-1:0] e);
    exp_q.push_back(e);
    rd_req <= 1'b1;
    rd_addr <= a;
    cyc(1);
    rd_req <= 1'b0;
    cyc(1);
  endtask

  // Readout compared against the oldest note
  always @(posedge clk) begin
    if (rd_valid_q === 1'b1 && exp_q.size() > 0) check(rd_data_q, exp_q.pop_front());
  end

  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    cyc(12);
    rst <= 1'b0;
    cyc(2);
    // Owner beats, a foreign beat and an unpacked trigger beat
    go();
    for (int i = 0; i < 4; i++) begin
      dv[i] = nxt();
      src.beat(owner_id, dv[i]);
    end
    src.beat(7'h11, nxt());
    src.beat(TRIG_ID, nxt());
    src.idle();
    cyc(3);
    check(fill_q, 9'h004);
    check(drop_cnt_q, 16'h0001);
    check(irq_status_q[EVT_WM], 1'b1);
    check(core_private_irq_q, 1'b1);
    check(shared_irq_q, 1'b1);
    for (int i = 0; i < 4; i++) rd(PTR_W'(i), {owner_id, dv[i]});
    clr();
    check(irq_status_q, EVT_NONE);
    check(shared_irq_q, 1'b0);
    // Event 0 stops a running capture at once
    event0_en <= 1'b1;
    stop_on_trig <= 1'b1;
    src.pulse();
    cyc(3);
    check(triggered_q, 1'b1);
    check(cap_active_q, 1'b0);
    check(irq_status_q[EVT_TRIG], 1'b1);
    // Shared buffer, packed trigger beat, two stores after trigger
    event0_en <= 1'b0;
    multi_src <= 1'b1;
    pack_trig <= 1'b1;
    trig_id_en <= 1'b1;
    post_trig_words <= 9'h002;
    clr();
    go();
    dv[0] = nxt();
    dv[1] = nxt();
    src.beat(TRIG_ID, dv[0]);
    src.beat(7'h22, dv[1]);
    src.idle();
    cyc(3);
    dv[2] = nxt();
    src.beat(7'h33, dv[2]);
    src.beat(7'h44, nxt());
    src.idle();
    cyc(3);
    check(fill_q, 9'h003);
    check(cap_active_q, 1'b0);
    check(core_private_irq_q, 1'b0);
    check(shared_irq_q, 1'b1);
    rd(PTR_ZERO, {TRIG_ID, dv[0]});
    rd(PTR_ONE, {7'h22, dv[1]});
    rd(8'h02, {7'h33, dv[2]});
    // Circular run through the whole buffer
    multi_src <= 1'b0;
    pack_trig <= 1'b0;
    trig_id_en <= 1'b0;
    stop_on_trig <= 1'b0;
    circ_mode <= 1'b1;
    watermark <= FILL_ZERO;
    clr();
    go();
    repeat (256) src.beat(owner_id, nxt());
    src.idle();
    cyc(3);
    check(irq_status_q[EVT_WRAP], 1'b1);
    check(fill_q, BUF_DEPTH);
    check(wr_ptr_q, PTR_ZERO);
    rd(PTR_LAST, {owner_id, lf});
    // Closed authentication refuses beats; stop ends a running capture
    dbg_auth_ok <= 1'b0;
    src.beat(owner_id, nxt());
    src.idle();
    dbg_auth_ok <= 1'b1;
    cap_stop <= 1'b1;
    cyc(1);
    cap_stop <= 1'b0;
    cyc(2);
    check(wr_ptr_q, PTR_ZERO);
    check(cap_active_q, 1'b0);
    // Linear run stops on the last slot without a wrap event
    circ_mode <= 1'b0;
    clr();
    go();
    repeat (257) src.beat(owner_id, nxt());
    src.idle();
    cyc(3);
    check(cap_active_q, 1'b0);
    check(fill_q, BUF_DEPTH);
    check(irq_status_q[EVT_WRAP], 1'b0);
    cyc(3);
    summarize();
  end
endmodule

bind tcs_capture_sink tcs_capture_sink_props u_props (.clk, .rst, .trace_valid, .trace_id, .owner_id, .multi_src,
  .pack_trig, .dbg_auth_ok, .event0, .event0_en, .stop_on_trig, .post_trig_words, .circ_mode, .watermark, .irq_en,
  .irq_clr, .cap_active_q, .triggered_q, .wr_ptr_q, .fill_q, .drop_cnt_q, .irq_status_q, .core_private_irq_q,
  .shared_irq_q, .message_locality_irq_q);

// ==== dv/tcs_trace_src.sv ====
`timescale 1ns/1ns
module tcs_trace_src import tcs_pkg::*; (
  // Clock and flow control
  input  wire logic         clk,
  input  wire logic         ready,
  // Stream and event toward the sink
  output logic              valid,
  output logic [ID_W-1:0]   id,
  output logic [DATA_W-1:0] data,
  output logic              evt0
);
  // Quiet at time zero
  initial begin
    valid = 1'b0;
    id = 7'h00;
    data = 32'h0000_0000;
    evt0 = 1'b0;
  end

  // Beat held until ready is seen on an edge; back to back keeps valid up
  task automatic beat(input logic [ID_W-1:0] i, input logic [DATA_W-1:0] d);
    valid <= 1'b1;
    id <= i;
    data <= d;
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
  endtask

  // Released lines flip so no stale beat is visible
  task automatic idle();
    valid <= 1'b0;
    id <= ~id;
    data <= ~data;
  endtask

  // One-cycle event 0
  task automatic pulse();
    evt0 <= 1'b1;
    @(posedge clk);
    evt0 <= 1'b0;
  endtask
endmodule

// ==== rtl/tcs_capture_sink.sv ====
// Function
// R1 - Trigger ID or event 0 stops capture
// R2 - Trigger traffic dropped or packed into store
// R3 - Circular mode interrupts on reaching buffer top
// R4 - Interrupt when fill reaches programmed watermark
// R5 - Single-source buffer: private, shared or message irq
// R6 - Multi-source buffer: shared or message irq only
// R7 - Warm core reset leaves capture state intact
// R8 - Firmware opens debug authentication before boot
// R9 - Non-secure or implemented state debug enabled
// R10 - Path bridges need no software configuration
// R11 - Dedicated buffer stores only its owner's trace
// R12 - No steering shared with other units' paths
// R13 - Buffer controls in own 64KB page
// R14 - Per-unit steering in separate 64KB pages
// R15 - Stage-two translator in own 64KB page
// R16 - Shared or message interrupt offered
// R17 - Sticky flags hold irq until cleared
`timescale 1ns/1ns
module tcs_capture_sink import tcs_pkg::*; (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Trace stream from trace unit
  input  wire logic              trace_valid,
  input  wire logic [ID_W-1:0]   trace_id,
  input  wire logic [DATA_W-1:0] trace_data,
  output logic                   trace_ready_q,
  // Dedicated event 0 from trace unit
  input  wire logic              event0,
  // Capture control
  input  wire logic              cap_start,
  input  wire logic              cap_stop,
  input  wire logic              circ_mode,
  input  wire logic              multi_src,
  input  wire logic              pack_trig,
  input  wire logic              trig_id_en,
  input  wire logic              event0_en,
  input  wire logic              stop_on_trig,
  input  wire logic [FILL_W-1:0] post_trig_words,
  input  wire logic [ID_W-1:0]   owner_id,
  input  wire logic              dbg_auth_ok,
  input  wire logic [FILL_W-1:0] watermark,
  // Interrupt control
  input  wire logic [NUM_EVT-1:0] irq_en,
  input  wire logic [NUM_EVT-1:0] irq_clr,
  // Buffer readout
  input  wire logic              rd_req,
  input  wire logic [PTR_W-1:0]  rd_addr,
  output logic [WORD_W-1:0]      rd_data_q,
  output logic                   rd_valid_q,
  // Status
  output logic                   cap_active_q,
  output logic                   triggered_q,
  output logic [PTR_W-1:0]       wr_ptr_q,
  output logic [FILL_W-1:0]      fill_q,
  output logic [CNT_W-1:0]       drop_cnt_q,
  output logic [NUM_EVT-1:0]     irq_status_q,
  // Interrupt outputs
  output logic                   core_private_irq_q,
  output logic                   shared_irq_q,
  output logic                   message_locality_irq_q
);

  // Reserved trigger identifier check
  function automatic logic is_trig_id(input logic [ID_W-1:0] id);
    return id == TRIG_ID;
  endfunction

  // Saturating increment of the fill level
  function automatic logic [FILL_W-1:0] fill_inc(input logic [FILL_W-1:0] f);
    return (f == BUF_DEPTH) ? f : f + FILL_ONE;
  endfunction

  // Run or post-trigger window; both accept beats
  function automatic logic is_live(input tcs_cap_state_e s);
    return (s == CAP_RUN) || (s == CAP_POST);
  endfunction

  // Capture storage
  logic [WORD_W-1:0] mem [0:(1 << PTR_W)-1];

  tcs_cap_state_e     state_q;
  tcs_cap_state_e     state_d;
  logic [PTR_W-1:0]   wr_ptr_d;
  logic [FILL_W-1:0]  fill_d;
  logic [FILL_W-1:0]  post_cnt_q;
  logic [FILL_W-1:0]  post_cnt_d;
  logic               triggered_d;
  logic               cap_active_d;
  logic [CNT_W-1:0]   drop_cnt_d;
  logic [WORD_W-1:0]  rd_data_d;
  logic               rd_valid_d;
  logic               trace_ready_d;
  logic               mem_we;
  logic [PTR_W-1:0]   mem_waddr;
  logic [WORD_W-1:0]  mem_wdata;

  logic               beat;
  logic               beat_trig;
  logic               beat_own;
  logic               admit;
  logic               at_last;
  logic               capturing;
  logic               store;
  logic               foreign;
  logic               trig_hit;
  logic               top_hit;
  logic               lin_full;
  logic               wm_cross;
  logic [NUM_EVT-1:0] evt;

  // Event bundle toward the interrupt unit
  tcs_irq_if irq_bus ();

  // Beat qualification on the stream
  always_comb begin
    // Ready never drops: bridges ahead of us need no setup to flow
    beat      = trace_valid & trace_ready_q; // R10
    beat_trig = beat & is_trig_id(trace_id);
    // Only the owner's ID is kept unless several units share us
    beat_own  = multi_src | (trace_id == owner_id); // R11 R12
    capturing = is_live(state_q);
    foreign   = beat & ~beat_own & ~beat_trig; // R11
  end

  // Store decision and capture events
  always_comb begin
    // Debug authentication is opened by firmware before we see trace
    admit    = beat & capturing & dbg_auth_ok; // R8 R9
    store    = admit & beat_own & ~is_trig_id(trace_id) // R11
             | admit & beat_trig & pack_trig; // R2
    trig_hit = capturing & ~triggered_q
             & ((beat_trig & trig_id_en) | (event0 & event0_en)); // R1
    at_last  = wr_ptr_q == PTR_LAST;
    top_hit  = store & circ_mode & at_last; // R3
    lin_full = store & ~circ_mode & at_last;
    // Crossing, not level: a parked fill must not re-raise a cleared flag
    wm_cross = store & (watermark != FILL_ZERO)
             & (fill_q < watermark) & (fill_inc(fill_q) >= watermark); // R4
    evt            = EVT_NONE;
    evt[EVT_WRAP]  = top_hit; // R3
    evt[EVT_WM]    = wm_cross; // R4
    evt[EVT_TRIG]  = trig_hit; // R1
  end

  // Hand events to the interrupt unit
  assign irq_bus.evt   = evt;
  assign irq_bus.en    = irq_en;
  assign irq_bus.clr   = irq_clr;
  assign irq_bus.multi = multi_src;

  // Capture state sequencing
  always_comb begin
    state_d     = state_q;
    post_cnt_d  = post_cnt_q;
    triggered_d = triggered_q | trig_hit;
    unique case (state_q)
      CAP_IDLE, CAP_STOP: begin
        if (cap_start) begin
          state_d     = CAP_RUN;
          triggered_d = 1'b0;
        end
      end
      CAP_RUN: begin
        if (cap_stop || lin_full) begin
          state_d = CAP_STOP;
        end else if (trig_hit && stop_on_trig) begin
          // Post-trigger window lets the follow-on context land before stopping
          if (post_trig_words == FILL_ZERO) begin
            state_d = CAP_STOP; // R1
          end else begin
            state_d    = CAP_POST; // R1
            post_cnt_d = post_trig_words;
          end
        end
      end
      CAP_POST: begin
        if (cap_stop || lin_full) begin
          state_d = CAP_STOP;
        end else if (store) begin
          post_cnt_d = post_cnt_q - FILL_ONE;
          if (post_cnt_q == FILL_ONE) begin
            state_d = CAP_STOP; // R1
          end
        end
      end
      default: begin
        // Illegal one-hot code falls back to idle
        state_d = CAP_IDLE;
      end
    endcase
    cap_active_d = is_live(state_d);
  end

  // Capture state registers; cold reset only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin // R7
      state_q      <= CAP_IDLE;
      post_cnt_q   <= FILL_ZERO;
      triggered_q  <= 1'b0;
      cap_active_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      post_cnt_q   <= post_cnt_d;
      triggered_q  <= triggered_d;
      cap_active_q <= cap_active_d;
    end
  end

  // Write pointer, fill level and drop count
  always_comb begin
    wr_ptr_d   = wr_ptr_q;
    fill_d     = fill_q;
    drop_cnt_d = drop_cnt_q;
    // Start rewinds the buffer; sticky interrupt flags are left for software
    if ((state_q == CAP_IDLE || state_q == CAP_STOP) && cap_start) begin
      wr_ptr_d   = PTR_ZERO;
      fill_d     = FILL_ZERO;
      drop_cnt_d = CNT_ZERO;
    end else begin
      if (store) begin
        // Pointer wraps in both modes; linear mode stops on the last slot
        wr_ptr_d = wr_ptr_q + PTR_ONE; // R3
        fill_d   = fill_inc(fill_q); // R4
      end
      // Foreign traffic is swallowed, never stored; counter saturates
      if (foreign && capturing && drop_cnt_q != CNT_MAX) begin
        drop_cnt_d = drop_cnt_q + CNT_ONE; // R11
      end
    end
  end

  // Pointer registers survive warm core reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin // R7
      wr_ptr_q   <= PTR_ZERO;
      fill_q     <= FILL_ZERO;
      drop_cnt_q <= CNT_ZERO;
    end else begin
      wr_ptr_q   <= wr_ptr_d;
      fill_q     <= fill_d;
      drop_cnt_q <= drop_cnt_d;
    end
  end

  // Write port; trigger beats keep their ID when packed
  always_comb begin
    mem_we    = store;
    mem_waddr = wr_ptr_q;
    mem_wdata = {trace_id, trace_data}; // R2
  end

  // Storage array; no reset, contents only valid below the fill level
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // Readout selection
  always_comb begin
    // Data holds between reads so a slow reader may sample late
    rd_valid_d = rd_req;
    rd_data_d  = rd_req ? mem[rd_addr] : rd_data_q;
  end

  // Readout registers; a read racing a write to the same slot sees old data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_q  <= WORD_ZERO;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // Stream ready; held high after reset so the sink never stalls the source
  always_comb begin
    trace_ready_d = 1'b1; // R10
  end

  // Stream ready register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trace_ready_q <= 1'b0;
    end else begin
      trace_ready_q <= trace_ready_d;
    end
  end

  // Sticky status and interrupt delivery
  tcs_irq_unit u_irq (
    .clk                    (clk),
    .rst                    (rst),
    .irq                    (irq_bus),
    .status_q               (irq_status_q),
    .core_private_irq_q     (core_private_irq_q),
    .shared_irq_q           (shared_irq_q),
    .message_locality_irq_q (message_locality_irq_q)
  );

endmodule

// ==== rtl/tcs_irq_if.sv ====
`timescale 1ns/1ns
interface tcs_irq_if;
  import tcs_pkg::*;

  logic [NUM_EVT-1:0] evt;
  logic [NUM_EVT-1:0] en;
  logic [NUM_EVT-1:0] clr;
  logic               multi;

  // Capture side raises events, interrupt unit consumes them
  modport src  (output evt, output en, output clr, output multi);
  modport sink (input evt, input en, input clr, input multi);
endinterface

// ==== rtl/tcs_irq_unit.sv ====
`timescale 1ns/1ns
module tcs_irq_unit import tcs_pkg::*; (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Events and control from capture logic
  tcs_irq_if.sink           irq,
  // Interrupt outputs
  output logic [NUM_EVT-1:0] status_q,
  output logic              core_private_irq_q,
  output logic              shared_irq_q,
  output logic              message_locality_irq_q
);

  logic [NUM_EVT-1:0] status_d;
  logic               pend_d;
  logic               core_private_irq_d;
  logic               shared_irq_d;
  logic               message_locality_irq_d;

  // Sticky flags; an event in the clear cycle still sets
  always_comb begin
    status_d               = (status_q & ~irq.clr) | irq.evt; // R17
    pend_d                 = |(status_d & irq.en); // R17
    shared_irq_d           = pend_d; // R6 R16
    // Private line only for a single-source buffer
    core_private_irq_d     = pend_d & ~irq.multi; // R5 R6
    // One message per new assertion, so a level never floods the bus
    message_locality_irq_d = pend_d & ~shared_irq_q; // R5 R6
  end

  // Cold reset only; warm core reset does not reach here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q               <= EVT_NONE;
      core_private_irq_q     <= 1'b0;
      shared_irq_q           <= 1'b0;
      message_locality_irq_q <= 1'b0;
    end else begin
      status_q               <= status_d;
      core_private_irq_q     <= core_private_irq_d;
      shared_irq_q           <= shared_irq_d;
      message_locality_irq_q <= message_locality_irq_d;
    end
  end

endmodule

// ==== rtl/tcs_pkg.sv ====
package tcs_pkg;

  // Stream and storage geometry
  localparam int ID_W    = 7;
  localparam int DATA_W  = 32;
  localparam int WORD_W  = ID_W + DATA_W;
  localparam int PTR_W   = 8;
  localparam int FILL_W  = PTR_W + 1;
  localparam int CNT_W   = 16;

  // Interrupt event bit positions
  localparam int NUM_EVT  = 3;
  localparam int EVT_WRAP = 0;
  localparam int EVT_WM   = 1;
  localparam int EVT_TRIG = 2;

  // Reserved trigger source identifier
  localparam logic [ID_W-1:0]    TRIG_ID   = 7'h7d;

  // Pointer and level constants
  localparam logic [FILL_W-1:0]  BUF_DEPTH = 9'h100;
  localparam logic [FILL_W-1:0]  FILL_ZERO = 9'h000;
  localparam logic [FILL_W-1:0]  FILL_ONE  = 9'h001;
  localparam logic [PTR_W-1:0]   PTR_ZERO  = 8'h00;
  localparam logic [PTR_W-1:0]   PTR_ONE   = 8'h01;
  localparam logic [PTR_W-1:0]   PTR_LAST  = 8'hff;
  localparam logic [CNT_W-1:0]   CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0]   CNT_ONE   = 16'h0001;
  localparam logic [CNT_W-1:0]   CNT_MAX   = 16'hffff;
  localparam logic [NUM_EVT-1:0] EVT_NONE  = 3'h0;
  localparam logic [WORD_W-1:0]  WORD_ZERO = 39'h00_0000_0000;

  // Control page of one buffer; no other buffer or steering element shares it
  localparam logic [31:0] CTRL_PAGE_BYTES = 32'h0001_0000; // R13 R14 R15

  // Capture state
  typedef enum logic [3:0] {
    CAP_IDLE = 4'h1,
    CAP_RUN  = 4'h2,
    CAP_POST = 4'h4,
    CAP_STOP = 4'h8
  } tcs_cap_state_e;

endpackage
